// file: rtl/ocs_osc_select.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module ocs_osc_select #(
    parameter int unsigned SLOW_DIV    = ocs_pkg::SLOW_OSC_DIV,
    parameter int unsigned FAIL_CYCLES = ocs_pkg::FAIL_CYC
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // configuration straps
    input  wire ocs_pkg::ocs_cfg_t first_config_word,
    // oscillator pins
    input  wire logic             osc_in_i,
    output logic                  osc_in_o,
    output logic                  osc_in_oe,
    input  wire logic             osc_out_i,
    output logic                  osc_out_o,
    output logic                  osc_out_oe,
    // general purpose use of the pins
    input  wire logic [1:0]       gpio_out,
    input  wire logic [1:0]       gpio_oe,
    output logic      [1:0]       gpio_in,
    // clock fabric
    output logic                  sys_clk_tick,
    output logic      [1:0]       xtal_gain,
    // axi4-lite write
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [11:0]      awaddr,
    input  wire logic             wvalid,
    output logic                  wready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    output logic                  bvalid,
    input  wire logic             bready,
    output logic      [1:0]       bresp,
    // axi4-lite read
    input  wire logic             arvalid,
    output logic                  arready,
    input  wire logic [11:0]      araddr,
    output logic                  rvalid,
    input  wire logic             rready,
    output logic      [31:0]      rdata,
    output logic      [1:0]       rresp
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ocs_pkg::ocs_cfg_t cfg;
        logic [1:0]        pin_s1;
        logic [1:0]        pin_s2;
        logic              in_s3;
        logic [10:0]       ost_cnt;
        logic              ost_done;
        logic [9:0]        warm_cnt;
        logic              fast_ok;
        logic              slow_ok;
        logic [15:0]       fail_cnt;
        logic              fail_flag;
        logic [2:0]        irf;
        logic              clk_sel;
        logic              cfg_run;
        logic [6:0]        post_cnt;
        logic [1:0]        div_cnt;
        logic              sys_tick;
        logic              in_o;
        logic              in_oe;
        logic              out_o;
        logic              out_oe;
        logic [1:0]        gain;
        logic              awready;
        logic              wready;
        logic              aw_got;
        logic              w_got;
        logic [11:0]       aw_addr;
        logic [7:0]        wbyte;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rbyte;
    } ocs_state_t;

    ocs_state_t st;
    ocs_state_t next_st;

    logic fast_tick;
    logic slow_tick;
    logic xtal;
    logic ext;
    logic ext_edge;
    logic use_ext;
    logic hold;
    logic int_tick;
    logic mon_on;
    logic fail_evt;
    logic wr_go;
    logic fail_clr;
    logic [6:0] mask;
    ocs_pkg::ocs_mode_t mode;

    // ------------------------------------------------------------
    // internal oscillators
    // ------------------------------------------------------------
    ocs_tick_div #(.DIV(ocs_pkg::FAST_OSC_DIV)) u_fast_osc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (fast_tick)
    );

    ocs_tick_div #(.DIV(SLOW_DIV)) u_slow_osc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (slow_tick)
    );

    function automatic logic [6:0] post_mask(input logic [2:0] sel);
        logic [6:0] m;
        m = 7'h00;
        unique case (sel)
            3'h7: m = 7'h00;
            3'h6: m = 7'h01;
            3'h5: m = 7'h03;
            3'h4: m = 7'h07;
            3'h3: m = 7'h0F;
            3'h2: m = 7'h1F;
            3'h1: m = 7'h3F;
            3'h0: m = 7'h00;
        endcase
        return m;
    endfunction : post_mask

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st  = st;
        mode     = st.cfg.clock_mode_cfg;
        xtal     = (mode == ocs_pkg::low_power_crystal_mode) ||
                   (mode == ocs_pkg::medium_gain_crystal_mode) ||
                   (mode == ocs_pkg::high_gain_crystal_mode);
        ext      = xtal || (mode == ocs_pkg::ext_logic_clock_mode) ||
                   (mode == ocs_pkg::resistor_capacitor_pin_io_mode) ||
                   (mode == ocs_pkg::resistor_capacitor_clkout_mode);
        ext_edge = st.pin_s2[0] & ~st.in_s3;
        wr_go    = st.aw_got && st.w_got && !st.bvalid;
        fail_clr = wr_go && st.wstrb0 && (st.aw_addr == ocs_pkg::ADDR_OSC_STATUS) &&
                   st.wbyte[ocs_pkg::STAT_FAIL_BIT];

        // pin synchronisers
        next_st.pin_s1 = {osc_out_i, osc_in_i};
        next_st.pin_s2 = st.pin_s1;
        next_st.in_s3  = st.pin_s2[0];

        // start-up timer counts pin oscillations in crystal modes
        if (xtal && !st.ost_done && ext_edge && (st.ost_cnt != ocs_pkg::OST_COUNT)) begin
            next_st.ost_cnt = st.ost_cnt + 11'h001;
        end
        if (!xtal || (st.ost_cnt == ocs_pkg::OST_COUNT)) begin
            next_st.ost_done = 1'b1;
        end

        // stability flags
        if (!st.fast_ok) begin
            next_st.warm_cnt = st.warm_cnt + 10'h001;
            if (st.warm_cnt == 10'(ocs_pkg::FAST_WARM_CYC - 1)) begin
                next_st.fast_ok = 1'b1;
            end
        end
        if (slow_tick) begin
            next_st.slow_ok = 1'b1;
        end

        // fail-safe watch on external edges
        mon_on = st.cfg.fail_mon_en && ext && st.ost_done && !st.clk_sel;
        if (ext_edge || !mon_on) begin
            next_st.fail_cnt = 16'h0000;
        end else if (st.fail_cnt != 16'(FAIL_CYCLES)) begin
            next_st.fail_cnt = st.fail_cnt + 16'h0001;
        end
        fail_evt = mon_on && (st.fail_cnt == 16'(FAIL_CYCLES));
        next_st.fail_flag = (st.fail_flag && !fail_clr) || fail_evt;

        // clock source choice
        use_ext = ext && !st.clk_sel && st.ost_done && !st.fail_flag;
        hold    = xtal && !st.ost_done && !st.clk_sel &&
                  !st.cfg.two_speed_en && !st.cfg.fail_mon_en;
        mask    = post_mask(st.irf);
        if (fast_tick) begin
            next_st.post_cnt = st.post_cnt + 7'h01;
        end
        if (st.irf == 3'h0) begin
            int_tick = slow_tick;
        end else begin
            int_tick = fast_tick && ((st.post_cnt & mask) == mask);
        end
        next_st.sys_tick = use_ext ? ext_edge : (!hold && int_tick);
        next_st.cfg_run  = use_ext;
        if (st.sys_tick) begin
            next_st.div_cnt = st.div_cnt + 2'h1;
        end

        // pin usage per mode
        next_st.in_o   = gpio_out[0];
        next_st.in_oe  = gpio_oe[0];
        next_st.out_o  = gpio_out[1];
        next_st.out_oe = gpio_oe[1];
        next_st.gain   = 2'h0;
        unique case (mode)
            ocs_pkg::low_power_crystal_mode,
            ocs_pkg::medium_gain_crystal_mode,
            ocs_pkg::high_gain_crystal_mode: begin
                next_st.in_oe  = 1'b0;
                next_st.out_o  = ~st.pin_s2[0];
                next_st.out_oe = 1'b1;
                next_st.gain   = 2'(mode) + 2'h1;
            end
            ocs_pkg::ext_logic_clock_mode,
            ocs_pkg::resistor_capacitor_pin_io_mode: begin
                next_st.in_oe = 1'b0;
            end
            ocs_pkg::resistor_capacitor_clkout_mode: begin
                next_st.in_oe  = 1'b0;
                next_st.out_o  = st.div_cnt[1];
                next_st.out_oe = 1'b1;
            end
            ocs_pkg::internal_osc_clkout_mode: begin
                next_st.out_o  = st.div_cnt[1];
                next_st.out_oe = 1'b1;
            end
            ocs_pkg::internal_osc_pin_io_mode: begin
                next_st.in_oe = gpio_oe[0];
            end
        endcase

        // write channel
        if (awvalid && st.awready) begin
            next_st.aw_addr = awaddr;
            next_st.aw_got  = 1'b1;
            next_st.awready = 1'b0;
        end
        if (wvalid && st.wready) begin
            next_st.wbyte  = wdata[7:0];
            next_st.wstrb0 = wstrb[0];
            next_st.w_got  = 1'b1;
            next_st.wready = 1'b0;
        end
        if (wr_go) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = ocs_pkg::RESP_OKAY;
            if (st.aw_addr == ocs_pkg::ADDR_OSC_CONTROL) begin
                if (st.wstrb0) begin
                    next_st.irf = st.wbyte[ocs_pkg::CTRL_IRF_LSB +: 3];
                    next_st.clk_sel = st.wbyte[ocs_pkg::CTRL_SEL_BIT];
                end
            end else if (st.aw_addr != ocs_pkg::ADDR_OSC_STATUS) begin
                next_st.bresp = ocs_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && bready) begin
            next_st.bvalid  = 1'b0;
            next_st.aw_got  = 1'b0;
            next_st.w_got   = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // read channel
        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = ocs_pkg::RESP_OKAY;
            next_st.rbyte   = 8'h00;
            if (araddr == ocs_pkg::ADDR_OSC_CONTROL) begin
                next_st.rbyte = {1'b0, st.irf, st.cfg_run, st.fast_ok, st.slow_ok,
                                 st.clk_sel};
            end else if (araddr == ocs_pkg::ADDR_OSC_STATUS) begin
                next_st.rbyte = {1'b0, 3'(st.cfg.clock_mode_cfg), st.cfg.fail_mon_en,
                                 st.cfg.two_speed_en, st.ost_done, st.fail_flag};
            end else begin
                next_st.rresp = ocs_pkg::RESP_SLVERR;
            end
        end
        if (st.rvalid && rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.cfg     <= first_config_word;
            st.irf     <= ocs_pkg::IRF_RESET;
            st.clk_sel <= ocs_pkg::SEL_RESET;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign osc_in_o     = st.in_o;
    assign osc_in_oe    = st.in_oe;
    assign osc_out_o    = st.out_o;
    assign osc_out_oe   = st.out_oe;
    assign gpio_in      = st.pin_s2;
    assign sys_clk_tick = st.sys_tick;
    assign xtal_gain    = st.gain;
    assign awready      = st.awready;
    assign wready       = st.wready;
    assign bvalid       = st.bvalid;
    assign bresp        = st.bresp;
    assign arready      = st.arready;
    assign rvalid       = st.rvalid;
    assign rresp        = st.rresp;
    assign rdata        = {24'h000000, st.rbyte};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_top_bit_zero: assert property (rvalid |-> !rdata[7])
        else $error("unimplemented control bit read as one");
    a_ext_edge_tick: assert property (use_ext && ext_edge |=> sys_clk_tick)
        else $error("external edge did not make a system tick");
    a_sel_internal: assert property ($rose(st.clk_sel) |-> ##[1:2] !st.cfg_run)
        else $error("clock select did not move to internal");
    a_ost_hold: assert property (hold |=> !sys_clk_tick)
        else $error("system ticked during crystal start-up");
    a_ost_count: assert property (xtal && $rose(st.ost_done) |-> st.ost_cnt == 11'h400)
        else $error("start-up timer ended on wrong count");
    a_clkout_drive: assert property ((mode == ocs_pkg::resistor_capacitor_clkout_mode ||
        mode == ocs_pkg::internal_osc_clkout_mode) |=> osc_out_oe)
        else $error("clock out pin not driven");
    a_clkout_div: assert property (sys_clk_tick && st.div_cnt == 2'h1 &&
        mode == ocs_pkg::internal_osc_clkout_mode |=> ##1 osc_out_o)
        else $error("clock out not divided by four");
    a_fail_fallback: assert property (fail_evt |=> ##1 !st.cfg_run)
        else $error("no fallback after clock failure");
    a_io_free: assert property (mode == ocs_pkg::internal_osc_pin_io_mode |=>
        osc_out_oe == $past(gpio_oe[1]) && osc_in_oe == $past(gpio_oe[0]))
        else $error("pins not released to general use");
    a_fast_rate: assert property (st.irf == 3'h7 && !use_ext && !hold && fast_tick
        |=> sys_clk_tick)
        else $error("fastest internal rate missed a tick");

endmodule : ocs_osc_select

// file: rtl/ocs_pkg.sv
package ocs_pkg;

    // ------------------------------------------------------------
    // clock source modes held in first_config_word
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        low_power_crystal_mode         = 3'h0,
        medium_gain_crystal_mode       = 3'h1,
        high_gain_crystal_mode         = 3'h2,
        ext_logic_clock_mode           = 3'h3,
        internal_osc_pin_io_mode       = 3'h4,
        internal_osc_clkout_mode       = 3'h5,
        resistor_capacitor_pin_io_mode = 3'h6,
        resistor_capacitor_clkout_mode = 3'h7
    } ocs_mode_t;

    typedef struct packed {
        ocs_mode_t clock_mode_cfg;
        logic      two_speed_en;
        logic      fail_mon_en;
    } ocs_cfg_t;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_OSC_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_OSC_STATUS  = 12'h004;
    localparam int          CTRL_SEL_BIT     = 0;
    localparam int          CTRL_SLOW_OK_BIT = 1;
    localparam int          CTRL_FAST_OK_BIT = 2;
    localparam int          CTRL_CFG_RUN_BIT = 3;
    localparam int          CTRL_IRF_LSB     = 4;
    localparam int          STAT_FAIL_BIT    = 0;
    localparam int          STAT_OST_BIT     = 1;
    localparam int          STAT_TWO_BIT     = 2;
    localparam int          STAT_MON_BIT     = 3;
    localparam int          STAT_MODE_LSB    = 4;
    localparam logic [2:0]  IRF_RESET        = 3'h6;
    localparam logic        SEL_RESET        = 1'b0;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_KHZ          = 250000;
    localparam int          CLK_PERIOD_NS    = 4;
    localparam int          FAST_OSC_KHZ     = 8000;
    localparam int          SLOW_OSC_KHZ     = 31;
    localparam int          FAST_OSC_DIV     = CLK_KHZ / FAST_OSC_KHZ;
    localparam int          SLOW_OSC_DIV     = CLK_KHZ / SLOW_OSC_KHZ;
    localparam int          FAST_WARM_NS     = 2000;
    localparam int          FAST_WARM_CYC    = (FAST_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FAIL_TIME_US     = 100;
    localparam int          FAIL_CYC         = FAIL_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [10:0] OST_COUNT        = 11'h400;

endpackage : ocs_pkg

// file: rtl/ocs_tick_div.sv
`timescale 1ns/1ns
module ocs_tick_div #(
    parameter int unsigned DIV = 31
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // one pulse every DIV cycles
    output logic      tick
);

    typedef struct packed {
        logic [13:0] cnt;
        logic        tick;
    } ocs_div_state_t;

    ocs_div_state_t st;
    ocs_div_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 14'(DIV - 1)) begin
            next_st.cnt  = 14'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 14'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : ocs_tick_div

// file: tb/ocs_clk_src.sv
`timescale 1ns/1ns
module ocs_clk_src #(
    parameter int HALF = 4
) (
    // clock and control
    input  wire logic aclk,
    input  wire logic run,
    // pin level
    output logic      pin
);
    // ----------------------------------------
    // external source, parked low while stopped
    // ----------------------------------------
    int cnt = 0;
    initial pin = 1'b0;
    always @(posedge aclk) begin
        if (!run) begin
            cnt <= 0;
            pin <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            pin <= ~pin;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : ocs_clk_src

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic              aclk, aresetn, run, pin, out_q, tgl;
    ocs_pkg::ocs_cfg_t cfg;
    logic              osc_in_i, osc_in_o, osc_in_oe, osc_out_i, osc_out_o, osc_out_oe;
    logic              sys_clk_tick, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        gpio_out, gpio_oe, gpio_in, xtal_gain, bresp, rresp, rr;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata, rd;
    logic [3:0]        wstrb;
    logic [6:0]        rows [8];
    int                errors = 0, n_compared = 0, nt = 0, nr = 0, t0, r0, ex;

    assign osc_in_i  = osc_in_oe ? osc_in_o : pin;
    // undriven out pin wanders every cycle
    assign osc_out_i = osc_out_oe ? osc_out_o : tgl;

    ocs_clk_src u_ocs_clk_src (.aclk(aclk), .run(run), .pin(pin));

    ocs_osc_select #(.SLOW_DIV(40), .FAIL_CYCLES(50)) u_ocs_osc_select (
        .aclk(aclk), .aresetn(aresetn), .first_config_word(cfg),
        .osc_in_i(osc_in_i), .osc_in_o(osc_in_o), .osc_in_oe(osc_in_oe),
        .osc_out_i(osc_out_i), .osc_out_o(osc_out_o), .osc_out_oe(osc_out_oe),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .sys_clk_tick(sys_clk_tick), .xtal_gain(xtal_gain),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (sys_clk_tick === 1'b1) nt <= nt + 1;
        if (osc_out_o === 1'b1 && out_q === 1'b0) nr <= nr + 1;
        out_q <= osc_out_o;
        tgl   <= ~tgl;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task chkn(input string s, input int e, input int g, input int tol);
        n_compared++;
        if (g < e - tol || g > e + tol) begin
            errors++;
            $display("unexpected %s expected %0d seen %0d", s, e, g);
        end
    endtask : chkn

    task rst(input logic [4:0] c);
        aresetn <= 1'b0;
        cfg     <= ocs_pkg::ocs_cfg_t'(c);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : rst

    task axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        rr = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axw

    task axr(input logic [11:0] a);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axr

    task rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
        axr(a);
        chk(s, {24'h0, e}, rd & {24'h0, m});
    endtask : rdc

    initial begin
        #400000;
        errors++;
        conclude();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {aresetn, run, awvalid, wvalid, bready, arvalid, rready, out_q, tgl} = '0;
        {awaddr, araddr, wdata} = '0;
        cfg      = '0;
        wstrb    = 4'hF;
        gpio_out = 2'h3;
        gpio_oe  = 2'h1;
        // mode, in pin oe, out pin oe, gain
        rows = '{7'h05, 7'h16, 7'h27, 7'h30, 7'h48, 7'h5C, 7'h60, 7'h74};
        for (int i = 0; i < 8; i++) begin
            rst({rows[i][6:4], 2'h0});
            repeat (10) @(posedge aclk);
            chk("in_oe", rows[i][3], osc_in_oe);
            chk("out_oe", rows[i][2], osc_out_oe);
            chk("gain", rows[i][1:0], xtal_gain);
            chk("gpio_in", rows[i][3], gpio_in[0]);
            rdc(12'h004, 8'h7C, {1'b0, rows[i][6:4], 4'h0}, "mode");
        end
        $display("test modes done");
        rst(5'h10);
        rdc(12'h000, 8'hFF, 8'h60, "ctrl reset");
        repeat (600) @(posedge aclk);
        rdc(12'h000, 8'h06, 8'h06, "stable");
        axw(12'h000, 32'hFFFFFFFF);
        rdc(12'h000, 8'hF1, 8'h71, "ctrl write");
        axw(12'h008, 32'h0);
        chk("bresp", ocs_pkg::RESP_SLVERR, rr);
        axr(12'h008);
        chk("rresp", ocs_pkg::RESP_SLVERR, rr);
        chk("rdata", 32'h0, rd);
        $display("test registers done");
        rst(5'h14);
        for (int f = 0; f < 8; f++) begin
            axw(12'h000, 32'(f << 4));
            repeat (8) @(posedge aclk);
            t0 = nt;
            r0 = nr;
            repeat (1984) @(posedge aclk);
            ex = (f == 0) ? 1984 / 40 : 1984 / (31 << (7 - f));
            chkn("ticks", ex, nt - t0, 1);
            if (f == 7) chkn("clkout", (nt - t0) / 4, nr - r0, 1);
        end
        $display("test rates done");
        rst(5'h0D);
        rdc(12'h000, 8'h08, 8'h00, "startup_timeout_status reset");
        run <= 1'b1;
        repeat (100) @(posedge aclk);
        rdc(12'h000, 8'h08, 8'h08, "startup_timeout_status ext");
        t0 = nt;
        repeat (400) @(posedge aclk);
        chkn("ext ticks", 50, nt - t0, 2);
        axw(12'h000, 32'h61);
        repeat (10) @(posedge aclk);
        rdc(12'h000, 8'h08, 8'h00, "startup_timeout_status int");
        axw(12'h000, 32'h60);
        repeat (20) @(posedge aclk);
        rdc(12'h000, 8'h08, 8'h08, "startup_timeout_status back");
        run <= 1'b0;
        repeat (150) @(posedge aclk);
        rdc(12'h004, 8'h01, 8'h01, "fail flag");
        rdc(12'h000, 8'h08, 8'h00, "startup_timeout_status fail");
        t0 = nt;
        repeat (200) @(posedge aclk);
        chkn("fallback", 3, nt - t0, 1);
        $display("test fail monitor done");
        rst(5'h00);
        run <= 1'b1;
        t0 = nt;
        repeat (7000) @(posedge aclk);
        chkn("held", 0, nt - t0, 0);
        rdc(12'h004, 8'h02, 8'h00, "timer busy");
        repeat (2500) @(posedge aclk);
        rdc(12'h004, 8'h02, 8'h02, "timer done");
        rdc(12'h000, 8'h08, 8'h08, "startup_timeout_status xtal");
        run <= 1'b0;
        $display("test start-up done");
        conclude();
    end
endmodule : tb
